// ---- serial_defines.vh ----
`ifndef SERIAL_DEFINES_VH
`define SERIAL_DEFINES_VH

// ========================================
// Register byte offsets.
`define OFF_CONTROL 8'h00
`define OFF_STATUS 8'h04
`define OFF_MODE 8'h08
`define OFF_TXHOLD 8'h0C
`define OFF_RXHOLD 8'h10
`define OFF_IRQ_STAT 8'h14
`define OFF_IRQ_MASK 8'h18
`define OFF_STOP 8'h1C

// ========================================
// Control register bit positions.
`define CTL_TXIE 7
`define CTL_RXIE 6
`define CTL_TXEN 5
`define CTL_RXEN 4
`define CTL_AWIE 3
`define CTL_TX_END_IRQ_ENABLE 2
`define CTL_CKE1 1

// ========================================
// Mode register bit positions.
`define MODE_SYNC 7
`define MODE_PAR 5
`define MODE_MP 2

// ========================================
// Reset values and bus responses.
`define CONTROL_RST 8'h00
`define MODE_RST 8'h00
`define STATUS_RST 8'h84
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ---- serial_ctrl.v ----
`include "serial_defines.vh"

module serial_ctrl
(
    // Clock and synchronous active-low reset.
    input wire clk,
    input wire rst_n,
    // AXI4-Lite write channels.
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read channels.
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // Pins from the line, asynchronous to clk.
    input wire rxd_pin,
    input wire sck_pin,
    // Shift engine handshake, same clock.
    input wire tx_shift_taken,
    input wire tx_last_bit,
    input wire rx_busy,
    input wire rx_word_done,
    input wire [7:0] rx_word,
    input wire rx_word_addr_bit,
    input wire rx_frame_err,
    input wire rx_parity_err,
    // Towards the shift engine.
    output wire [7:0] tx_data,
    output wire tx_go,
    output wire rx_start,
    output wire [7:0] mode_out,
    output wire [7:0] control_out,
    // Interrupt requests.
    output wire rx_full_irq,
    output wire rx_error_irq,
    output wire tx_end_irq,
    output wire tx_empty_irq,
    output wire irq
);
    // ========================================
    // Register state.
    reg [7:0] control_reg, control_next;
    reg [7:0] mode_reg, mode_next;
    reg [7:0] tx_holding_reg, tx_holding_next;
    reg [7:0] rx_holding_reg, rx_holding_next;
    reg [7:0] armed_reg, armed_next;
    reg [3:0] istat_reg, istat_next;
    reg [3:0] imask_reg, imask_next;
    reg stop_reg, stop_next;
    reg tx_buf_empty_flag_reg, tx_buf_empty_flag_next, rx_buf_full_flag_reg, rx_buf_full_flag_next;
    reg overrun_error_flag_reg, overrun_error_flag_next, fer_reg, fer_next, per_reg, per_next;
    reg tx_end_flag_reg, tx_end_flag_next, mpb_reg, mpb_next, mpbt_reg, mpbt_next;
    reg [3:0] req_reg, req_next;
    reg irq_reg, irq_next;
    reg rx_start_reg, rx_start_next;
    reg tx_go_reg;
    // Pin synchronisers plus one edge-history stage each.
    reg rxd_s1_reg, rxd_s2_reg, rxd_d_reg;
    reg sck_s1_reg, sck_s2_reg, sck_d_reg;
    // Bus slave state.
    reg aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
    reg [7:0] aw_addr_reg;
    reg [7:0] w_data_reg;
    reg w_lane_reg;
    reg [1:0] bresp_reg, rresp_reg;
    reg [31:0] rdata_reg;
    wire wr_en, rd_en, addr_wait, wr_ok;
    wire [7:0] status_byte;
    // A write is performed once address and data are both held.
    assign wr_en = aw_full_reg & w_full_reg & ~bvalid_reg;
    assign rd_en = s_axi_arvalid & ~rvalid_reg;
    assign wr_ok = wr_en & w_lane_reg;
    assign status_byte = {tx_buf_empty_flag_reg, rx_buf_full_flag_reg, overrun_error_flag_reg, fer_reg,
                          per_reg, tx_end_flag_reg, mpb_reg, mpbt_reg};
    // Address-wait only counts in asynchronous multidrop format.
    assign addr_wait = ~mode_reg[`MODE_SYNC] & mode_reg[`MODE_MP] &
                       control_reg[`CTL_AWIE];
    // ========================================
    // Next-state logic for registers, flags and requests.
    always @*
    begin
        control_next = control_reg;
        mode_next = mode_reg;
        tx_holding_next = tx_holding_reg;
        rx_holding_next = rx_holding_reg;
        armed_next = armed_reg;
        imask_next = imask_reg;
        stop_next = stop_reg;
        {tx_buf_empty_flag_next, rx_buf_full_flag_next, overrun_error_flag_next, fer_next,
         per_next, tx_end_flag_next, mpb_next, mpbt_next} = status_byte;
        istat_next = istat_reg;
        // Software writes come first so that hardware sets below win.
        if (wr_ok)
        begin
            case (aw_addr_reg)
                `OFF_CONTROL: control_next = w_data_reg;
                `OFF_MODE: mode_next = w_data_reg;
                `OFF_TXHOLD: tx_holding_next = w_data_reg;
                `OFF_IRQ_MASK: imask_next = w_data_reg[3:0];
                `OFF_IRQ_STAT: istat_next = istat_reg & ~w_data_reg[3:0];
                `OFF_STOP: stop_next = w_data_reg[0];
                `OFF_STATUS:
                begin
                    // A flag clears only if it was read as one first; the transmit end flag clears with the transmit empty flag, on its read.
                    if (armed_reg[7] & ~w_data_reg[7])
                    begin
                        tx_buf_empty_flag_next = 1'b0;
                        tx_end_flag_next = 1'b0;
                    end
                    if (armed_reg[6] & ~w_data_reg[6])
                        rx_buf_full_flag_next = 1'b0;
                    if (armed_reg[5] & ~w_data_reg[5])
                        overrun_error_flag_next = 1'b0;
                    if (armed_reg[4] & ~w_data_reg[4])
                        fer_next = 1'b0;
                    if (armed_reg[3] & ~w_data_reg[3])
                        per_next = 1'b0;
                    mpbt_next = w_data_reg[0];
                    armed_next = 8'h00;
                end
                default: armed_next = armed_reg;
            endcase
        end
        // Reading the status arms each flag seen as one.
        if (rd_en && s_axi_araddr == `OFF_STATUS)
            armed_next = status_byte;
        // Received word; the receive enable bit does not touch flags.
        if (rx_word_done && control_reg[`CTL_RXEN])
        begin
            if (addr_wait && !rx_word_addr_bit)
                rx_buf_full_flag_next = rx_buf_full_flag_next;
            else
            begin
                if (addr_wait)
                    control_next[`CTL_AWIE] = 1'b0;
                if (~mode_reg[`MODE_SYNC] & mode_reg[`MODE_MP])
                    mpb_next = rx_word_addr_bit;
                if (rx_buf_full_flag_reg)
                    overrun_error_flag_next = 1'b1;
                else if (rx_frame_err && !mode_reg[`MODE_SYNC])
                    fer_next = 1'b1;
                else if (rx_parity_err && mode_reg[`MODE_PAR] &&
                         !mode_reg[`MODE_MP] && !mode_reg[`MODE_SYNC])
                    per_next = 1'b1;
                else
                begin
                    rx_holding_next = rx_word;
                    rx_buf_full_flag_next = 1'b1;
                end
            end
        end
        // Transmit side events.
        if (tx_shift_taken)
            tx_buf_empty_flag_next = 1'b1;
        if (tx_last_bit && tx_buf_empty_flag_reg)
            tx_end_flag_next = 1'b1;
        if (!control_next[`CTL_TXEN])
            tx_buf_empty_flag_next = 1'b1;
        // Module stop puts control and status back to reset state.
        if (stop_next)
        begin
            control_next = `CONTROL_RST;
            {tx_buf_empty_flag_next, rx_buf_full_flag_next, overrun_error_flag_next, fer_next,
             per_next, tx_end_flag_next, mpb_next, mpbt_next} = `STATUS_RST;
        end
        // Requests follow the next flag and enable values together.
        req_next[0] = rx_buf_full_flag_next & control_next[`CTL_RXIE];
        req_next[1] = (overrun_error_flag_next | fer_next | per_next) &
                      control_next[`CTL_RXIE];
        req_next[2] = tx_end_flag_next & control_next[`CTL_TX_END_IRQ_ENABLE];
        req_next[3] = tx_buf_empty_flag_next & control_next[`CTL_TXIE];
        // Sticky bits catch each rising request; set beats clear.
        istat_next = istat_next | (req_next & ~req_reg);
        irq_next = |(istat_next & imask_next);
        // Start detection on synchronised pins.
        rx_start_next = control_reg[`CTL_RXEN] & ~rx_busy &
            (mode_reg[`MODE_SYNC] ?
             (sck_s2_reg & ~sck_d_reg & control_reg[`CTL_CKE1]) :
             (~rxd_s2_reg & rxd_d_reg));
    end
    // ========================================
    // Register update.
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            control_reg <= `CONTROL_RST;
            mode_reg <= `MODE_RST;
            {tx_holding_reg, rx_holding_reg, armed_reg} <= 24'h00_0000;
            {istat_reg, imask_reg} <= 8'h00;
            stop_reg <= 1'b0;
            {tx_buf_empty_flag_reg, rx_buf_full_flag_reg, overrun_error_flag_reg, fer_reg,
             per_reg, tx_end_flag_reg, mpb_reg, mpbt_reg} <= `STATUS_RST;
            req_reg <= 4'h0;
            irq_reg <= 1'b0;
            rx_start_reg <= 1'b0;
            tx_go_reg <= 1'b0;
        end
        else
        begin
            control_reg <= control_next;
            mode_reg <= mode_next;
            tx_holding_reg <= tx_holding_next;
            rx_holding_reg <= rx_holding_next;
            armed_reg <= armed_next;
            istat_reg <= istat_next;
            imask_reg <= imask_next;
            stop_reg <= stop_next;
            {tx_buf_empty_flag_reg, rx_buf_full_flag_reg, overrun_error_flag_reg, fer_reg,
             per_reg, tx_end_flag_reg, mpb_reg, mpbt_reg} <=
                {tx_buf_empty_flag_next, rx_buf_full_flag_next, overrun_error_flag_next, fer_next,
                 per_next, tx_end_flag_next, mpb_next, mpbt_next};
            req_reg <= req_next;
            irq_reg <= irq_next;
            rx_start_reg <= rx_start_next;
            // Holding data is valid for the engine once the flag drops.
            tx_go_reg <= control_next[`CTL_TXEN] & ~tx_buf_empty_flag_next;
        end
    end
    // ========================================
    // Pin synchronisers; the first stage feeds only the second.
    // Both pins reset to their idle high level so no false edge follows.
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            {rxd_d_reg, rxd_s2_reg, rxd_s1_reg} <= 3'h7;
            {sck_d_reg, sck_s2_reg, sck_s1_reg} <= 3'h7;
        end
        else
        begin
            {rxd_d_reg, rxd_s2_reg, rxd_s1_reg} <=
                {rxd_s2_reg, rxd_s1_reg, rxd_pin};
            {sck_d_reg, sck_s2_reg, sck_s1_reg} <=
                {sck_s2_reg, sck_s1_reg, sck_pin};
        end
    end
    // ========================================
    // AXI4-Lite slave; address and data may arrive in either order.
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 8'h00;
            w_lane_reg <= 1'b0;
            bresp_reg <= `RESP_OKAY;
            rresp_reg <= `RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            if (s_axi_awvalid && !aw_full_reg)
            begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_full_reg)
            begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata[7:0];
                w_lane_reg <= s_axi_wstrb[0];
            end
            if (wr_en)
            begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                // Unmapped or unaligned addresses answer with an error.
                bresp_reg <= (aw_addr_reg > `OFF_STOP ||
                              aw_addr_reg[1:0] != 2'h0) ?
                             `RESP_SLVERR : `RESP_OKAY;
            end
            else if (bvalid_reg && s_axi_bready)
                bvalid_reg <= 1'b0;
            if (rd_en)
            begin
                rvalid_reg <= 1'b1;
                rresp_reg <= `RESP_OKAY;
                case (s_axi_araddr)
                    `OFF_CONTROL: rdata_reg <= {24'h00_0000, control_reg};
                    `OFF_STATUS: rdata_reg <= {24'h00_0000, status_byte};
                    `OFF_MODE: rdata_reg <= {24'h00_0000, mode_reg};
                    `OFF_TXHOLD: rdata_reg <= {24'h00_0000, tx_holding_reg};
                    `OFF_RXHOLD: rdata_reg <= {24'h00_0000, rx_holding_reg};
                    `OFF_IRQ_STAT: rdata_reg <= {28'h000_0000, istat_reg};
                    `OFF_IRQ_MASK: rdata_reg <= {28'h000_0000, imask_reg};
                    `OFF_STOP: rdata_reg <= {31'h0000_0000, stop_reg};
                    default:
                    begin
                        rdata_reg <= 32'h0000_0000;
                        rresp_reg <= `RESP_SLVERR;
                    end
                endcase
            end
            else if (rvalid_reg && s_axi_rready)
                rvalid_reg <= 1'b0;
        end
    end
    // ========================================
    // Outputs, each straight from a flip-flop.
    assign s_axi_awready = ~aw_full_reg;
    assign s_axi_wready = ~w_full_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign tx_data = tx_holding_reg;
    assign tx_go = tx_go_reg;
    assign rx_start = rx_start_reg;
    assign mode_out = mode_reg;
    assign control_out = control_reg;
    assign rx_full_irq = req_reg[0];
    assign rx_error_irq = req_reg[1];
    assign tx_end_irq = req_reg[2];
    assign tx_empty_irq = req_reg[3];
    assign irq = irq_reg;
endmodule

// ---- serial_ctrl_props.sv ----
`include "serial_defines.vh"

// ========================================
// Checker for enable and request gating.
module serial_ctrl_props
(
    // Clock and reset.
    input wire clk,
    input wire rst_n,
    // Engine handshake.
    input wire tx_shift_taken,
    input wire tx_last_bit,
    input wire rx_word_done,
    input wire rx_word_addr_bit,
    // Observed outputs.
    input wire tx_go,
    input wire rx_start,
    input wire [7:0] mode_out,
    input wire [7:0] control_out,
    input wire rx_full_irq,
    input wire rx_error_irq,
    input wire tx_end_irq,
    input wire tx_empty_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // A word that lands while the unit waits for an address word.
    sequence s_wait_word;
        control_out[`CTL_AWIE] && control_out[`CTL_RXEN] &&
            mode_out[`MODE_MP] && !mode_out[`MODE_SYNC] && rx_word_done;
    endsequence
    sequence s_rx_quiet;
        !rx_full_irq && !rx_error_irq;
    endsequence

    // Requests are the flag gated by the enable, so a low enable wins.
    a_rx_gate: assert property (
        !control_out[`CTL_RXIE] |-> !rx_full_irq && !rx_error_irq)
        else $error("receive request without its enable");
    a_end_gate: assert property (
        !control_out[`CTL_TX_END_IRQ_ENABLE] |-> !tx_end_irq)
        else $error("transmit end request without its enable");
    a_empty_gate: assert property (
        !control_out[`CTL_TXIE] |-> !tx_empty_irq)
        else $error("transmit empty request without its enable");
    a_empty_set: assert property (
        control_out[`CTL_TXIE] && tx_shift_taken ##1 control_out[`CTL_TXIE]
        |-> tx_empty_irq)
        else $error("no transmit empty request after hand-off");
    // Start request and enable are registered from the same next value.
    a_tx_idle: assert property (
        !control_out[`CTL_TXEN] |-> !tx_go)
        else $error("transmit started while disabled");
    a_end_set: assert property (
        tx_last_bit && !tx_go && control_out[`CTL_TX_END_IRQ_ENABLE]
        ##1 control_out[`CTL_TX_END_IRQ_ENABLE] |-> tx_end_irq)
        else $error("no transmit end request at last bit");
    a_wait_drop: assert property (
        s_wait_word ##0 !rx_word_addr_bit ##0 s_rx_quiet |=> s_rx_quiet)
        else $error("data word accepted during address wait");
    a_wait_end: assert property (
        s_wait_word ##0 rx_word_addr_bit |=> !control_out[`CTL_AWIE])
        else $error("address wait not ended by address word");
    a_start_gate: assert property (
        rx_start |-> $past(control_out[`CTL_RXEN]))
        else $error("reception started while disabled");
endmodule

bind serial_ctrl serial_ctrl_props i_props (.clk(clk), .rst_n(rst_n),
    .tx_shift_taken(tx_shift_taken), .tx_last_bit(tx_last_bit),
    .rx_word_done(rx_word_done), .rx_word_addr_bit(rx_word_addr_bit),
    .tx_go(tx_go), .rx_start(rx_start), .mode_out(mode_out),
    .control_out(control_out), .rx_full_irq(rx_full_irq),
    .rx_error_irq(rx_error_irq), .tx_end_irq(tx_end_irq),
    .tx_empty_irq(tx_empty_irq));

// ---- serial_line_model.sv ----
// ========================================
// Shift engines and line, as seen by the control block.
module serial_line_model
(
    // Clock and transmit request from the block.
    input wire clk,
    input wire tx_go,
    // Transmit engine handshake.
    output logic tx_shift_taken = 1'h0,
    output logic tx_last_bit = 1'h0,
    // Receive engine reports.
    output logic rx_busy = 1'h0,
    output logic rx_word_done = 1'h0,
    output logic [7:0] rx_word = 8'h00,
    output logic rx_word_addr_bit = 1'h0,
    output logic rx_frame_err = 1'h0,
    output logic rx_parity_err = 1'h0,
    // Line pins, idle high; the clock pin stands still between frames.
    output logic rxd_pin = 1'h1,
    output logic sck_pin = 1'h1
);
    timeunit 1ns;
    timeprecision 1ps;

    // Shifter takes offered data after a random stall, then ends a frame.
    always
    begin
        @(negedge clk);
        if (tx_go === 1'h1)
        begin
            repeat ($urandom_range(3, 0)) @(posedge clk);
            @(posedge clk);
            tx_shift_taken <= 1'h1;
            @(posedge clk);
            tx_shift_taken <= 1'h0;
            repeat (4) @(posedge clk);
            tx_last_bit <= 1'h1;
            @(posedge clk);
            tx_last_bit <= 1'h0;
        end
    end

    // One received word; report lines show inverted junk outside the pulse.
    task automatic send(input logic [7:0] d, input logic a, input logic fe);
        @(posedge clk);
        rxd_pin <= 1'h0;
        repeat (5) @(posedge clk);
        rx_busy <= 1'h1;
        repeat (3) @(posedge clk);
        rx_word <= d;
        rx_word_addr_bit <= a;
        rx_frame_err <= fe;
        rx_word_done <= 1'h1;
        @(posedge clk);
        rx_word_done <= 1'h0;
        rx_word <= ~d;
        rx_word_addr_bit <= ~a;
        rx_frame_err <= ~fe;
        rxd_pin <= 1'h1;
        rx_busy <= 1'h0;
        repeat (2) @(posedge clk);
    endtask
endmodule

// ---- serial_enable_irq_control_tb_top.sv ----
`include "serial_defines.vh"

// ========================================
// Bench for the control block.
module serial_enable_irq_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    wire awready, wready, bvalid, arready, rvalid, rx_parity_err, sck_pin;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire tx_shift_taken, tx_last_bit, rx_busy, rx_word_done, rxd_pin;
    wire rx_word_addr_bit, rx_frame_err, tx_go, rx_start, irq;
    wire rx_full_irq, rx_error_irq, tx_end_irq, tx_empty_irq;
    wire [7:0] rx_word, tx_data, mode_out, control_out;
    int errors = 0;
    int n_compared = 0;
    int n_starts = 0;
    logic [33:0] exp_q[$];
    logic [7:0] d;

    always #5 clk = ~clk;

    serial_ctrl i_dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .rxd_pin(rxd_pin), .sck_pin(sck_pin),
        .tx_shift_taken(tx_shift_taken), .tx_last_bit(tx_last_bit),
        .rx_busy(rx_busy), .rx_word_done(rx_word_done), .rx_word(rx_word),
        .rx_word_addr_bit(rx_word_addr_bit), .rx_frame_err(rx_frame_err),
        .rx_parity_err(rx_parity_err), .tx_data(tx_data), .tx_go(tx_go),
        .rx_start(rx_start), .mode_out(mode_out),
        .control_out(control_out), .rx_full_irq(rx_full_irq),
        .rx_error_irq(rx_error_irq), .tx_end_irq(tx_end_irq),
        .tx_empty_irq(tx_empty_irq), .irq(irq));

    serial_line_model i_line (.clk(clk), .tx_go(tx_go),
        .tx_shift_taken(tx_shift_taken), .tx_last_bit(tx_last_bit),
        .rx_busy(rx_busy), .rx_word_done(rx_word_done), .rx_word(rx_word),
        .rx_word_addr_bit(rx_word_addr_bit), .rx_frame_err(rx_frame_err),
        .rx_parity_err(rx_parity_err), .rxd_pin(rxd_pin),
        .sck_pin(sck_pin));

    // ========================================
    // Reporting and bus tasks.
    task automatic results;
        if (errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    function automatic logic [33:0] ok(input logic [7:0] v);
        return {`RESP_OKAY, 24'h00_0000, v};
    endfunction

    // Outputs are sampled mid-cycle, away from the launching edge.
    task automatic pins(input logic [5:0] exp);
        @(negedge clk);
        chk({28'h000_0000, tx_go, irq, rx_full_irq, rx_error_irq,
            tx_end_irq, tx_empty_irq}, {28'h000_0000, exp});
    endtask

    // Handshakes are judged at the falling edge, released after the rise.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic aw_ok = 1'h0;
        logic w_ok = 1'h0;
        logic b_ok = 1'h0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h00_0000, v};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!b_ok)
        begin
            @(negedge clk);
            aw_ok = awvalid && awready;
            w_ok = wvalid && wready;
            b_ok = bvalid;
            @(posedge clk);
            if (aw_ok)
                awvalid <= 1'h0;
            if (w_ok)
                wvalid <= 1'h0;
            if (b_ok)
                bready <= 1'h0;
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] exp);
        logic ar_ok = 1'h0;
        logic r_ok = 1'h0;
        @(posedge clk);
        exp_q.push_back(exp);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        while (!r_ok)
        begin
            @(negedge clk);
            ar_ok = arvalid && arready;
            r_ok = rvalid;
            @(posedge clk);
            if (ar_ok)
                arvalid <= 1'h0;
            if (r_ok)
                rready <= 1'h0;
        end
    endtask

    // Read answers are matched against the oldest note.
    always @(negedge clk)
    begin
        if (rvalid && rready)
            chk({rresp, rdata}, exp_q.pop_front());
    end

    // Receive starts are counted so a missing or doubled pulse shows up.
    always @(negedge clk)
    begin
        if (rx_start === 1'h1)
            n_starts++;
    end

    // Hang guard, well beyond the few hundred cycles the run needs.
    initial
    begin
        #200000;
        errors++;
        results();
    end

    // ========================================
    // Main sequence.
    initial
    begin
        void'($urandom(32'h6e3b_afd2));
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        rd(`OFF_CONTROL, ok(8'h00));
        rd(`OFF_STATUS, ok(8'h84));
        rd(8'hF0, {`RESP_SLVERR, 32'h0000_0000});
        wr(`OFF_TXHOLD, 8'h5A);
        rd(`OFF_STATUS, ok(8'h84));
        wr(`OFF_MODE, 8'h00);
        wr(`OFF_CONTROL, 8'hA4);
        pins(6'h03);
        d = $urandom;
        wr(`OFF_TXHOLD, d);
        rd(`OFF_STATUS, ok(8'h84));
        wr(`OFF_STATUS, 8'h7E);
        pins(6'h20);
        chk({26'h000_0000, tx_data}, {26'h000_0000, d});
        for (int i = 0; i < 50 && tx_end_irq !== 1'h1; i++) @(negedge clk);
        pins(6'h03);
        wr(`OFF_CONTROL, 8'hA0);
        pins(6'h01);
        wr(`OFF_CONTROL, 8'h00);
        pins(6'h00);
        wr(`OFF_CONTROL, 8'h50);
        d = $urandom;
        i_line.send(d, 1'h0, 1'h0);
        pins(6'h08);
        rd(`OFF_RXHOLD, ok(d));
        rd(`OFF_STATUS, ok(8'hC4));
        wr(`OFF_CONTROL, 8'h10);
        pins(6'h00);
        wr(`OFF_CONTROL, 8'h40);
        pins(6'h08);
        rd(`OFF_STATUS, ok(8'hC4));
        wr(`OFF_STATUS, 8'hBE);
        pins(6'h00);
        wr(`OFF_IRQ_MASK, 8'h01);
        pins(6'h10);
        rd(`OFF_IRQ_STAT, ok(8'h0D));
        wr(`OFF_IRQ_STAT, 8'h01);
        pins(6'h00);
        rd(`OFF_IRQ_STAT, ok(8'h0C));
        wr(`OFF_IRQ_MASK, 8'h00);
        wr(`OFF_CONTROL, 8'h50);
        i_line.send(8'h3C, 1'h0, 1'h1);
        pins(6'h04);
        rd(`OFF_STATUS, ok(8'h94));
        wr(`OFF_STATUS, 8'hEE);
        pins(6'h00);
        wr(`OFF_CONTROL, 8'h00);
        wr(`OFF_MODE, 8'h04);
        wr(`OFF_CONTROL, 8'h58);
        i_line.send(8'hA5, 1'h0, 1'h0);
        pins(6'h00);
        rd(`OFF_STATUS, ok(8'h84));
        d = $urandom;
        i_line.send(d, 1'h1, 1'h0);
        pins(6'h08);
        rd(`OFF_CONTROL, ok(8'h50));
        rd(`OFF_STATUS, ok(8'hC6));
        rd(`OFF_RXHOLD, ok(d));
        i_line.send(8'h00, 1'h0, 1'h0);
        pins(6'h0C);
        rd(`OFF_STATUS, ok(8'hE4));
        wr(`OFF_STATUS, 8'hDE);
        pins(6'h08);
        wr(`OFF_STOP, 8'h01);
        rd(`OFF_CONTROL, ok(8'h00));
        wr(`OFF_STOP, 8'h00);
        chk(34'(n_starts), 34'h5);
        results();
    end
endmodule
